/* rtl/adps_result_mem.sv */
`timescale 1ns/1ps
module adps_result_mem (
  input  wire logic                            ref_clk,
  input  wire logic                            wr_en,
  input  wire logic [3:0]                      wr_addr,
  input  wire logic [adps_pkg::RES_W-1:0]      wr_data,
  input  wire logic                            rd_en,
  input  wire logic [3:0]                      rd_addr,
  output logic      [adps_pkg::RES_W-1:0]      rd_data
);

  logic [adps_pkg::RES_W-1:0] mem [0:adps_pkg::NUM_CH-1];

  // no reset on contents
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* rtl/adps_sequencer.sv */
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module adps_sequencer (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [adps_pkg::APB_AW-1:0]   paddr,
  input  wire logic [adps_pkg::APB_DW-1:0]   pwdata,
  output logic      [adps_pkg::APB_DW-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [adps_pkg::NUM_PAIRS-1:0] hw_trig,
  input  wire logic                          cpu_idle,
  input  wire logic [adps_pkg::RES_W-1:0]    afe_data,
  output adps_pkg::adps_afe_req_t            afe_req,
  output logic                               irq_req,
  output logic      [adps_pkg::NUM_CH-1:0]   pin_analog_en,
  output logic      [adps_pkg::NUM_CH-1:0]   pin_dir
);

  localparam int NP = adps_pkg::NUM_PAIRS;
  localparam int NC = adps_pkg::NUM_CH;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [2:0] lowest(input logic [NP-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic is_shared(input logic [3:0] ch);
    return ~adps_pkg::DED_SH_MASK[ch];
  endfunction

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  adps_pkg::adps_ctrl_t  ctrl_r;
  adps_pkg::adps_state_t state_r;
  logic [NP-1:0]         kick_r;
  logic [NP-1:0]         flight_r;
  logic [NP-1:0]         irqen_r;
  logic [NP-1:0]         trgen_r;
  logic [NP-1:0]         done_r;
  logic [15:0]           vbase_r;
  logic [NC-1:0]         pinsel_r;
  logic [NC-1:0]         pindir_r;
  logic [NC-1:0]         smp_done_r;
  logic [NC-1:0]         cvt_done_r;
  logic [4:0]            div_cnt_r;
  logic [4:0]            conv_cnt_r;
  logic [3:0]            conv_ch_r;
  logic                  sh_busy_r;
  logic                  sh_smp_r;
  logic [1:0]            sh_cnt_r;
  logic [3:0]            sh_owner_r;
  logic [adps_pkg::RES_W-1:0] mem_q;

  logic          run;
  logic          tick;
  logic [NP-1:0] trig;
  logic [NP-1:0] ded_fin;
  logic [NP-1:0] ded_smp;
  logic [NP-1:0] bg_vec;
  logic [2:0]    act_pair;
  logic [3:0]    first_ch;
  logic [3:0]    next_ch;
  logic [3:0]    other_ch;
  logic [2:0]    bg_pair;
  logic [2:0]    irq_pair;
  logic          need_sh;
  logic          bg_go;
  logic          sh_fin;
  logic          st_store;
  logic          pair_cmpl;
  logic          first_fin;
  logic          wr;
  logic          rd_setup;
  logic          is_res;
  logic          mapped;
  logic [3:0]    res_idx;
  logic [7:0]    res_off;

  // ---------------------------------------------------------------
  // run control and converter clock
  // ---------------------------------------------------------------
  assign run = ctrl_r.en & ~(ctrl_r.idle_halt_sel & cpu_idle);

  assign tick = run &&
    (div_cnt_r == adps_pkg::DIV_RATIO_TBL[ctrl_r.conv_clock_div_sel] - 5'h01);

  always_ff @(posedge ref_clk) begin
    if (rst || !run || tick) begin
      div_cnt_r <= 5'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // triggers and dedicated sample-and-hold
  // ---------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pair
      logic       ded_busy_r;
      logic [1:0] ded_cnt_r;

      assign trig[gp] = run & ~flight_r[gp] &
                        (kick_r[gp] | (trgen_r[gp] & (hw_trig[gp] | ctrl_r.global_soft_kick)));

      always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
          ded_busy_r <= 1'h0;
          ded_cnt_r  <= 2'h0;
        end else if (trig[gp] && !is_shared(4'(2 * gp))) begin
          ded_busy_r <= 1'h1;
          ded_cnt_r  <= 2'h0;
        end else if (ded_busy_r && tick) begin
          ded_cnt_r <= ded_cnt_r + 2'h1;
          if (ded_cnt_r == adps_pkg::SAMPLE_TICKS - 2'h1) begin
            ded_busy_r <= 1'h0;
          end
        end
      end

      assign ded_smp[gp] = ded_busy_r;
      assign ded_fin[gp] = ded_busy_r && tick &&
                           (ded_cnt_r == adps_pkg::SAMPLE_TICKS - 2'h1);
      assign bg_vec[gp]  = flight_r[gp] & ~is_shared(4'(2 * gp)) &
                           ~smp_done_r[2 * gp + 1] & ~cvt_done_r[2 * gp + 1];
    end
  endgenerate

  // ---------------------------------------------------------------
  // scheduling
  // ---------------------------------------------------------------
  assign act_pair = lowest(flight_r);
  assign first_ch = {act_pair, ctrl_r.order};
  assign next_ch  = cvt_done_r[first_ch] ? {act_pair, ~ctrl_r.order} : first_ch;
  assign bg_pair  = lowest(bg_vec);

  assign need_sh = tick && (state_r == adps_pkg::ST_IDLE) && (|flight_r) &&
                   !smp_done_r[next_ch] && is_shared(next_ch) && !sh_busy_r;
  assign bg_go   = tick && !need_sh && !sh_busy_r && (|bg_vec) &&
                   (!ctrl_r.sequential_sample_sel || ctrl_r.order);
  assign sh_fin  = sh_smp_r && tick && (sh_cnt_r == adps_pkg::SAMPLE_TICKS - 2'h1);

  assign st_store  = (state_r == adps_pkg::ST_STORE);
  assign other_ch  = {conv_ch_r[3:1], ~conv_ch_r[0]};
  assign pair_cmpl = st_store && cvt_done_r[other_ch];
  assign first_fin = st_store && !cvt_done_r[other_ch];

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      sh_busy_r  <= 1'h0;
      sh_smp_r   <= 1'h0;
      sh_cnt_r   <= 2'h0;
      sh_owner_r <= 4'h0;
    end else if (st_store && sh_busy_r && sh_owner_r == conv_ch_r) begin
      sh_busy_r <= 1'h0;
    end else if (need_sh || bg_go) begin
      sh_busy_r  <= 1'h1;
      sh_smp_r   <= 1'h1;
      sh_cnt_r   <= 2'h0;
      sh_owner_r <= need_sh ? next_ch : {bg_pair, 1'h1};
    end else if (sh_smp_r && tick) begin
      sh_cnt_r <= sh_cnt_r + 2'h1;
      if (sh_fin) begin
        sh_smp_r <= 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      smp_done_r <= '0;
      cvt_done_r <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (ded_fin[p]) begin
          smp_done_r[2 * p] <= 1'h1;
        end
      end
      if (sh_fin) begin
        smp_done_r[sh_owner_r] <= 1'h1;
      end
      if (first_fin) begin
        cvt_done_r[conv_ch_r] <= 1'h1;
      end
      if (pair_cmpl) begin
        smp_done_r[{conv_ch_r[3:1], 1'h0}] <= 1'h0;
        smp_done_r[{conv_ch_r[3:1], 1'h1}] <= 1'h0;
        cvt_done_r[{conv_ch_r[3:1], 1'h0}] <= 1'h0;
        cvt_done_r[{conv_ch_r[3:1], 1'h1}] <= 1'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // converter state machine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      state_r    <= adps_pkg::ST_IDLE;
      conv_cnt_r <= 5'h00;
      conv_ch_r  <= 4'h0;
    end else begin
      case (state_r)
        adps_pkg::ST_IDLE: begin
          if (tick && (|flight_r) && smp_done_r[next_ch]) begin
            state_r    <= adps_pkg::ST_CONV;
            conv_ch_r  <= next_ch;
            conv_cnt_r <= 5'h00;
          end
        end
        adps_pkg::ST_CONV: begin
          if (tick) begin
            conv_cnt_r <= conv_cnt_r + 5'h01;
            if (conv_cnt_r == adps_pkg::CH_CONV_TICKS - 5'h01) begin
              state_r <= adps_pkg::ST_STORE;
            end
          end
        end
        adps_pkg::ST_STORE: begin
          state_r <= adps_pkg::ST_IDLE;
        end
        default: begin
          state_r <= adps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pair control and status
  // ---------------------------------------------------------------
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kick_r  <= adps_pkg::PAIR_RST;
      irqen_r <= adps_pkg::PAIR_RST;
      trgen_r <= adps_pkg::PAIR_RST;
    end else begin
      kick_r <= (kick_r & ~trig) |
                ((wr && paddr == adps_pkg::OFF_PAIR) ?
                 pwdata[adps_pkg::PCTL_KICK_LSB +: NP] : adps_pkg::PAIR_RST);
      if (wr && paddr == adps_pkg::OFF_PAIR) begin
        irqen_r <= pwdata[adps_pkg::PCTL_IRQEN_LSB +: NP];
        trgen_r <= pwdata[adps_pkg::PCTL_TRGEN_LSB +: NP];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      flight_r <= adps_pkg::PAIR_RST;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (trig[p]) begin
          flight_r[p] <= 1'h1;
        end else if (pair_cmpl && conv_ch_r[3:1] == 3'(p)) begin
          flight_r[p] <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_r <= adps_pkg::PAIR_RST;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (irqen_r[p] && !done_r[p] && conv_ch_r[3:1] == 3'(p) &&
            (pair_cmpl || (first_fin && ctrl_r.first_channel_irq_en))) begin
          done_r[p] <= 1'h1;
        end else if (wr && paddr == adps_pkg::OFF_STAT && !pwdata[p]) begin
          done_r[p] <= 1'h0;
        end
      end
    end
  end

  assign irq_req  = |done_r;
  assign irq_pair = lowest(done_r);

  // ---------------------------------------------------------------
  // control, vector base and pin registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= adps_pkg::CTRL_RST;
    end else if (wr && paddr == adps_pkg::OFF_CTRL) begin
      ctrl_r        <= pwdata[15:0];
      ctrl_r.rsvd14 <= 1'h0;
      ctrl_r.rsvd12 <= 2'h0;
      ctrl_r.rsvd9  <= 1'h0;
      ctrl_r.rsvd4  <= 2'h0;
    end else if (run) begin
      ctrl_r.global_soft_kick <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vbase_r  <= adps_pkg::VBASE_RST;
      pinsel_r <= adps_pkg::PINSEL_RST;
      pindir_r <= adps_pkg::PINDIR_RST;
    end else if (wr) begin
      if (paddr == adps_pkg::OFF_VBASE) begin
        vbase_r <= pwdata[15:0];
      end
      if (paddr == adps_pkg::OFF_PINSEL) begin
        pinsel_r <= pwdata[NC-1:0];
      end
      if (paddr == adps_pkg::OFF_PINDIR) begin
        pindir_r <= pwdata[NC-1:0];
      end
    end
  end

  assign pin_analog_en = ~pinsel_r;
  assign pin_dir       = pindir_r;

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  assign res_off = paddr - adps_pkg::OFF_RES_BASE;
  assign res_idx = res_off[5:2];
  assign is_res  = (paddr >= adps_pkg::OFF_RES_BASE) && (paddr < adps_pkg::OFF_RES_END) &&
                   (paddr[1:0] == 2'h0);

  adps_result_mem u_mem (
    .ref_clk (ref_clk),
    .wr_en   (st_store),
    .wr_addr (conv_ch_r),
    .wr_data (afe_data),
    .rd_en   (rd_setup & is_res),
    .rd_addr (res_idx),
    .rd_data (mem_q)
  );

  // ---------------------------------------------------------------
  // bus read side
  // ---------------------------------------------------------------
  assign mapped = is_res || paddr == adps_pkg::OFF_CTRL || paddr == adps_pkg::OFF_PAIR ||
                  paddr == adps_pkg::OFF_STAT || paddr == adps_pkg::OFF_VBASE ||
                  paddr == adps_pkg::OFF_PINSEL || paddr == adps_pkg::OFF_PINDIR;

  assign pready  = 1'h1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = '0;
    if (is_res) begin
      if (ctrl_r.result_layout_sel == adps_pkg::LAYOUT_INT) begin
        prdata[15:0] = {6'h00, mem_q};
      end else begin
        prdata[15:0] = {mem_q, 6'h00};
      end
    end else begin
      case (paddr)
        adps_pkg::OFF_CTRL: begin
          prdata[15:0] = ctrl_r;
        end
        adps_pkg::OFF_PAIR: begin
          prdata[adps_pkg::PCTL_KICK_LSB +: NP]   = kick_r;
          prdata[adps_pkg::PCTL_FLIGHT_LSB +: NP] = flight_r;
          prdata[adps_pkg::PCTL_IRQEN_LSB +: NP]  = irqen_r;
          prdata[adps_pkg::PCTL_TRGEN_LSB +: NP]  = trgen_r;
        end
        adps_pkg::OFF_STAT: begin
          prdata[NP-1:0] = done_r;
        end
        adps_pkg::OFF_VBASE: begin
          prdata[15:0] = vbase_r + {12'h000, irq_pair, 1'h0};
        end
        adps_pkg::OFF_PINSEL: begin
          prdata[NC-1:0] = pinsel_r;
        end
        adps_pkg::OFF_PINDIR: begin
          prdata[NC-1:0] = pindir_r;
        end
        default: begin
          prdata = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // analog front end requests
  // ---------------------------------------------------------------
  always_comb begin
    afe_req             = '0;
    afe_req.conv_active = (state_r == adps_pkg::ST_CONV);
    afe_req.conv_chan   = conv_ch_r;
    for (int p = 0; p < NP; p++) begin
      afe_req.sample_en[2 * p] = ded_smp[p];
    end
    if (sh_smp_r) begin
      afe_req.sample_en[sh_owner_r] = 1'h1;
    end
  end

endmodule

/* shared/adps_pkg.sv */
package adps_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PAIRS = 6;
  localparam int NUM_CH    = 12;
  localparam int RES_W     = 10;
  localparam int WORD_W    = 16;
  localparam int APB_AW    = 8;
  localparam int APB_DW    = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_PAIR     = 8'h04;
  localparam logic [7:0] OFF_STAT     = 8'h08;
  localparam logic [7:0] OFF_VBASE    = 8'h0c;
  localparam logic [7:0] OFF_PINSEL   = 8'h10;
  localparam logic [7:0] OFF_PINDIR   = 8'h14;
  localparam logic [7:0] OFF_RES_BASE = 8'h40;
  localparam logic [7:0] OFF_RES_END  = 8'h70;

  // ---------------------------------------------------------------
  // pair control field positions
  // ---------------------------------------------------------------
  localparam int PCTL_KICK_LSB   = 0;
  localparam int PCTL_FLIGHT_LSB = 8;
  localparam int PCTL_IRQEN_LSB  = 16;
  localparam int PCTL_TRGEN_LSB  = 24;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0]        CTRL_RST   = 16'h0000;
  localparam logic [NUM_PAIRS-1:0] PAIR_RST = 6'h00;
  localparam logic [15:0]        VBASE_RST  = 16'h0000;
  localparam logic [NUM_CH-1:0]  PINSEL_RST = 12'h000;
  localparam logic [NUM_CH-1:0]  PINDIR_RST = 12'hfff;

  // channels with their own sample-and-hold
  localparam logic [NUM_CH-1:0] DED_SH_MASK = 12'h055;

  // ---------------------------------------------------------------
  // timing, in converter clock ticks
  // ---------------------------------------------------------------
  localparam logic [1:0] SAMPLE_TICKS    = 2'h2;
  localparam int         PAIR_CONV_TICKS = 24;
  localparam logic [4:0] CH_CONV_TICKS   = 5'(PAIR_CONV_TICKS / 2);
  localparam logic       LAYOUT_INT      = 1'h0;
  localparam logic [4:0] DIV_RATIO_TBL [0:7] = '{5'h02, 5'h04, 5'h06, 5'h08,
                                                 5'h0a, 5'h0e, 5'h10, 5'h12};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic       rsvd14;
    logic       idle_halt_sel;
    logic [1:0] rsvd12;
    logic       global_soft_kick;
    logic       rsvd9;
    logic       result_layout_sel;
    logic       first_channel_irq_en;
    logic       order;
    logic       sequential_sample_sel;
    logic [1:0] rsvd4;
    logic [2:0] conv_clock_div_sel;
  } adps_ctrl_t;

  typedef struct packed {
    logic              conv_active;
    logic [3:0]        conv_chan;
    logic [NUM_CH-1:0] sample_en;
  } adps_afe_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_CONV  = 3'h2,
    ST_STORE = 3'h4
  } adps_state_t;

endpackage

/* sim/adps_afe_model.sv */
`timescale 1ns/1ps
module adps_afe_model (
  input  wire logic                    ref_clk,
  input  wire adps_pkg::adps_afe_req_t afe_req,
  input  wire logic [5:0]              salt,
  output logic      [9:0]              afe_data
);
  logic act_r;

  always_ff @(posedge ref_clk) begin
    act_r <= afe_req.conv_active;
  end

  // value holds through the store cycle, scrambled otherwise
  assign afe_data = (afe_req.conv_active || act_r) ? {afe_req.conv_chan, salt}
                                                   : ~{afe_req.conv_chan, salt};
endmodule

/* sim/adps_sequencer_assertions.sv */
`timescale 1ns/1ps
module adps_seq_chk (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [5:0]              hw_trig,
  input wire logic                    cpu_idle,
  input wire logic [9:0]              afe_data,
  input wire adps_pkg::adps_afe_req_t afe_req,
  input wire logic                    irq_req,
  input wire logic [11:0]             pin_analog_en,
  input wire logic [11:0]             pin_dir
);
  // ----------------
  // control shadow
  // ----------------
  logic halt_r;
  logic lay_r;
  logic en_r;
  logic rd_acc;
  logic res_rd;
  assign rd_acc = psel && penable && !pwrite;
  assign res_rd = rd_acc && paddr >= 8'h40 && paddr < 8'h70;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_r <= 1'h0;
      lay_r  <= 1'h0;
      en_r   <= 1'h0;
    end else if (psel && penable && pwrite && paddr == 8'h00) begin
      halt_r <= pwdata[13];
      lay_r  <= pwdata[8];
      en_r   <= pwdata[15];
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  pin_reset_a: assert property ($fell(rst) |-> &pin_analog_en && pin_dir == 12'hfff)
    else $error("pins not analog after reset");
  reset_quiet_a: assert property ($fell(rst) |-> afe_req == '0 && !irq_req)
    else $error("converter active after reset");
  sample_first_a: assert property (
    afe_req.conv_active |-> !afe_req.sample_en[afe_req.conv_chan])
    else $error("conversion during sampling");
  shared_one_a: assert property ($onehot0(afe_req.sample_en & ~adps_pkg::DED_SH_MASK))
    else $error("shared hold used twice");
  ded_hold_a: assert property ($rose(afe_req.sample_en[0]) |-> afe_req.sample_en[0] [*3])
    else $error("dedicated sample too short");
  idle_abort_a: assert property (
    cpu_idle && halt_r && en_r |=> !afe_req.conv_active && afe_req.sample_en == '0)
    else $error("no abort in idle");
  res_int_a: assert property (res_rd && !lay_r |-> prdata[31:10] == '0)
    else $error("integer result not right aligned");
  res_frac_a: assert property (
    res_rd && lay_r |-> prdata[31:16] == '0 && prdata[5:0] == '0)
    else $error("fraction result not left aligned");
  irq_stat_a: assert property (rd_acc && paddr == 8'h08 |-> irq_req == (prdata[5:0] != '0))
    else $error("irq and done flags differ");
  cover property ($rose(afe_req.conv_active));
  cover property ($rose(irq_req));
  cover property (cpu_idle && afe_req.conv_active);
endmodule

bind adps_sequencer adps_seq_chk adps_seq_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_trig(hw_trig), .cpu_idle(cpu_idle), .afe_data(afe_data), .afe_req(afe_req),
  .irq_req(irq_req), .pin_analog_en(pin_analog_en), .pin_dir(pin_dir));

/* sim/tb_adps_sequencer.sv */
`timescale 1ns/1ps
module tb_adps_sequencer;
  logic        ref_clk, rst, psel, penable, pwrite, cpu_idle, pready, pslverr, irq_req;
  logic        err, lay;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, base, c;
  logic [5:0]  hw_trig, salt;
  logic [9:0]  afe_data;
  logic [11:0] pin_analog_en, pin_dir;
  adps_pkg::adps_afe_req_t afe_req;
  int          n_errors, checks_done, len, run, r;
  int          seed = 32'h7cb3;
  int          seen_q[$];

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  adps_sequencer adps_sequencer_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trig(hw_trig), .cpu_idle(cpu_idle), .afe_data(afe_data), .afe_req(afe_req),
    .irq_req(irq_req), .pin_analog_en(pin_analog_en), .pin_dir(pin_dir));
  adps_afe_model adps_afe_model_inst (
    .ref_clk(ref_clk), .afe_req(afe_req), .salt(salt), .afe_data(afe_data));

  // channel order and length of each conversion
  always @(posedge ref_clk) begin
    if (afe_req.conv_active) begin
      if (run == 0) seen_q.push_back(int'(afe_req.conv_chan));
      run = run + 1;
    end else begin
      if (run > 0) len = run;
      run = 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    do apb(1'b0, 8'h04, 32'h0); while (rd[13:8] !== 6'h00);
  endtask

  task automatic chk_reset();
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hfff};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset reg", rd, rv[i]);
    end
    chk("pin analog", {20'h0, pin_analog_en}, 32'hfff);
  endtask

  function automatic logic [31:0] fmt(input int ch, input logic l);
    logic [9:0] d;
    d = {4'(ch), salt};
    return l ? {16'h0, d, 6'h0} : {22'h0, d};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_trig = 6'h00;
    cpu_idle = 1'b0;
    salt = 6'h00;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_reset();
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    c = 32'($random(seed)) & 32'hfff;
    apb(1'b1, 8'h10, c);
    chk("pin select", {20'h0, ~pin_analog_en}, c);
    apb(1'b1, 8'h14, c);
    chk("pin dir", {20'h0, pin_dir}, c);
    for (int m = 0; m < 4; m++) begin
      salt <= 6'($random(seed));
      base = 32'($random(seed)) & 32'h7ffe;
      lay = m[0] ^ m[1];
      r = m[1] ? 14 : 2;
      c = {16'h0, 1'b1, 6'h0, lay, 1'b0, m[0], m[1], 2'h0, m[1] ? 3'h5 : 3'h0};
      apb(1'b1, 8'h00, c & 32'h7fff);
      apb(1'b1, 8'h00, c);
      apb(1'b1, 8'h0c, base);
      seen_q.delete();
      apb(1'b1, 8'h04, 32'h0003_0003);
      apb(1'b0, 8'h04, 32'h0);
      chk("kick", rd & 32'h3f3f, 32'h0300);
      wait_idle();
      chk("conv count", seen_q.size(), 4);
      foreach (seen_q[i]) chk("order", seen_q[i], i ^ m[0]);
      chk("conv ticks", (len + 1) / r, 12);
      for (int ch = 0; ch < 4; ch++) begin
        apb(1'b0, 8'(8'h40 + 4 * ch), 32'h0);
        chk("result", rd, fmt(ch, lay));
      end
      apb(1'b0, 8'h08, 32'h0);
      chk("done", rd, 32'h3);
      apb(1'b0, 8'h0c, 32'h0);
      chk("vector", rd, base);
      apb(1'b1, 8'h08, 32'h3e);
      apb(1'b0, 8'h0c, 32'h0);
      chk("vector", rd, base + 32'h2);
      apb(1'b1, 8'h08, 32'h0);
      chk("irq", {31'h0, irq_req}, 32'h0);
    end
    apb(1'b1, 8'h00, 32'ha000);
    apb(1'b1, 8'h04, 32'h0001_0001);
    repeat (20) @(posedge ref_clk);
    cpu_idle <= 1'b1;
    repeat (10) @(posedge ref_clk);
    cpu_idle <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("abort", rd & 32'h3f3f, 32'h0);
    apb(1'b1, 8'h00, 32'h8000);
    cpu_idle <= 1'b1;
    apb(1'b1, 8'h04, 32'h0001_0001);
    wait_idle();
    cpu_idle <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("idle run", rd, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h3c3c_0000);
    apb(1'b1, 8'h00, 32'h8080);
    hw_trig <= 6'h04 | (6'($random(seed)) & 6'h03);
    @(posedge ref_clk);
    hw_trig <= 6'h00;
    do apb(1'b0, 8'h08, 32'h0); while (rd[2] !== 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("early flag", rd[13:8], 6'h04);
    wait_idle();
    apb(1'b0, 8'h08, 32'h0);
    chk("hw trig", rd, 32'h4);
    apb(1'b1, 8'h00, 32'h8400);
    apb(1'b0, 8'h00, 32'h0);
    chk("global kick", rd, 32'h8000);
    wait_idle();
    apb(1'b0, 8'h08, 32'h0);
    chk("global done", rd, 32'h3c);
    apb(1'b1, 8'h04, 32'h0001_0001);
    repeat (10) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_reset();
    apb(1'b0, 8'h40, 32'h0);
    chk("kept result", rd, {22'h0, 4'h0, salt});
    summarize();
  end
endmodule
